// ==== design/byte_fifo.sv ====
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// The count is one bit wider than a pointer so that full can be told
	// apart from empty.
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wrPtr_ff;
	logic [PW-1:0]    rdPtr_ff;
	logic [PW:0]      count_ff;
	wire              doPush = inValid & inReady;
	wire              doPop  = outValid & outReady;
	wire [PW-1:0]     wrNext = (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
	wire [PW-1:0]     rdNext = (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;

	// Full and empty come from the true occupancy count.
	assign inReady  = (count_ff != FULL_COUNT);
	assign outValid = (count_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];

	// Storage is written only on an accepted push.
	always_ff @(posedge mclk) begin
		if (doPush) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end

	// Pointers and count; a push and a pop together keep the count.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (doPush) wrPtr_ff <= wrNext;
			if (doPop) rdPtr_ff <= rdNext;
			if (doPush && !doPop) count_ff <= count_ff + 1'b1;
			else if (doPop && !doPush) count_ff <= count_ff - 1'b1;
		end
	end

endmodule // byte_fifo
`default_nettype wire

// ==== design/serial_port_expander_io.sv ====
// Serially addressed 8-bit I/O port with compare flag and bit masks.
// Contract
// [R1] First byte after enable falls is control; later bytes are data or masks.
// [R2] Register select bit 0 targets data register, 1 targets direction register.
// [R3] Direction bit 0 means device sends; 1 means device receives.
// [R4] Format bits matter only for writes; reads ignore them.
// [R5] Format upper bit 0: received byte is written unchanged.
// [R6] Format 10: ones in the byte clear register bits.
// [R7] Format 11: ones in the byte set register bits.
// [R8] Compare select bits choose one of four compare conditions.
// [R9] Serial bits move most significant bit first both ways.
// [R10] One serial clock pulse per bit, transfers in whole bytes.
// [R11] Serial clock idle level at enable fall fixes edge polarity.
// [R12] Read sends compare information during control byte, then register bytes.
// [R13] Read repeats the selected register while enable stays low.
// [R14] Write sends old register contents while the data byte arrives.
// [R15] After a full write byte output floats and register loads.
// [R16] Port outputs change when the eighth data bit arrives; here they change when the queued byte is applied.
// [R17] Top two control bits must match identify pins to take part.
// [R18] Direction 0 is input, 1 output; reads mix live inputs and latches.
// [R19] Compare codes: any mismatch, all match, all mismatch, any match.
// [R20] Compare flag latched on every falling edge of enable.
// [R21] Identify mismatch keeps output floating until enable rises.
`include "serial_port_expander_io_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_port_expander_io #(
	parameter int QUEUE_DEPTH = `SPX_QUEUE_DEPTH
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Serial link pins
	input  wire logic       serialClk,
	input  wire logic       chipEnableN,
	input  wire logic       serialIn,
	output logic            serialOut,
	output logic            serialOutOe,
	// Hardwired identify pins
	input  wire logic       identify_bit_high,
	input  wire logic       identify_bit_low,
	// Port pins, three signals each
	input  wire logic [7:0] port_pinsIn,
	output logic      [7:0] port_pinsOut,
	output logic      [7:0] port_pinsOe,
	// User control and status
	input  wire logic       applyHold,
	output logic            compareFlag,
	output logic            writeQueueFull,
	output logic            byteDropped
);

	localparam int WW = $bits(serial_port_expander_io_pkg::wr_word_t);

	// Synchronised pin levels. Every pin crosses two flip-flops first, so
	// the engine reacts about three clocks after a pin moves; the serial
	// clock must hold each level for at least that long.
	logic [`SPX_SYNC_WIDTH-1:0] syncBus;
	wire        sckS   = syncBus[12];
	wire        ceNS   = syncBus[11];
	wire        mosiS  = syncBus[10];
	wire [1:0]  idS    = syncBus[9:8];
	wire [7:0]  pinS   = syncBus[7:0];

	// Engine state.
	serial_port_expander_io_pkg::phase_t   state_ff;
	serial_port_expander_io_pkg::phase_t   nxt_state;
	serial_port_expander_io_pkg::control_t ctrl_ff;
	logic       sckPrev_ff;
	logic       cePrev_ff;
	logic       idleLvl_ff;
	logic [2:0] bitCnt_ff;
	logic [6:0] inShift_ff;
	logic [6:0] outShift_ff;
	logic [1:0] cmpMode_ff;
	logic [7:0] dataReg_ff;
	logic [7:0] dirReg_ff;

	// Queue signals.
	serial_port_expander_io_pkg::wr_word_t pushWord;
	serial_port_expander_io_pkg::wr_word_t popWord;
	logic qInReady;
	logic qOutValid;

	sync_two_ff #(
		.WIDTH (`SPX_SYNC_WIDTH)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.din  ({serialClk, chipEnableN, serialIn, identify_bit_high,
		        identify_bit_low, port_pinsIn}),
		.dout (syncBus)
	);

	// Enable and serial clock edges; polarity was fixed at enable fall.
	// Clock movement is ignored while deselected, so a polarity change
	// between frames is harmless.
	wire ceFall  = cePrev_ff & ~ceNS;
	wire sckMove = (sckS != sckPrev_ff) & ~ceNS;
	wire sckLead = sckMove & (sckPrev_ff == idleLvl_ff); // [R11]
	wire sckTrail = sckMove & (sckS == idleLvl_ff); // [R11]

	// Engine phase decode.
	wire inCtrl  = (state_ff == serial_port_expander_io_pkg::ST_CTRL);
	wire inRead  = (state_ff == serial_port_expander_io_pkg::ST_READ);
	wire inWrite = (state_ff == serial_port_expander_io_pkg::ST_WRITE);
	wire inQuiet = (state_ff == serial_port_expander_io_pkg::ST_QUIET);
	wire talking = inCtrl | inRead | inWrite;

	// Receive path: eight trailing edges make one byte, MSB first.
	wire       byteDone = sckTrail & (bitCnt_ff == `SPX_LAST_BIT); // [R10]
	wire [7:0] rxByte   = {inShift_ff, mosiS}; // [R9]
	wire [1:0] rxId     = {inShift_ff[0], mosiS};
	wire       idCheck  = inCtrl & sckTrail & (bitCnt_ff == `SPX_ID_LAST_BIT);
	wire       idMiss   = idCheck & (rxId != idS); // [R17]
	serial_port_expander_io_pkg::control_t rxCtrl;
	assign rxCtrl = rxByte;

	// Compare: output pins count as equal to their latches.
	// Masking the output bits keeps a loaded pin from faking a mismatch.
	wire [7:0] mism   = ~dirReg_ff & (pinS ^ dataReg_ff); // [R19]
	wire       cmpNow = (cmpMode_ff == `SPX_CMP_ANY_MISMATCH) ? |mism :
	                    (cmpMode_ff == `SPX_CMP_ALL_MATCH)    ? ~|mism :
	                    (cmpMode_ff == `SPX_CMP_ALL_MISMATCH) ? &mism :
	                    ~&mism; // [R19]

	// Read view: inputs show live pins, outputs show the latch.
	wire [7:0] dataView = (dirReg_ff & dataReg_ff) | (~dirReg_ff & pinS); // [R18]
	wire [7:0] rawSel   = ctrl_ff.register_select_bit ? dirReg_ff
	                                                  : dataReg_ff; // [R2]
	wire [7:0] viewSel  = ctrl_ff.register_select_bit ? dirReg_ff
	                                                  : dataView; // [R2]

	// Byte loaded into the transmitter at each byte start.
	wire [7:0] cmpByte = {8{compareFlag}}; // [R12]
	wire [7:0] loadVal = inCtrl ? cmpByte :
	                     inRead ? viewSel : rawSel; // [R12] [R13] [R14]
	wire       byteStart = sckLead & (bitCnt_ff == 3'h0);
	wire       nxtMiso   = byteStart ? loadVal[7] : outShift_ff[6]; // [R9]
	wire [6:0] nxtOutShift = byteStart ? loadVal[6:0]
	                                   : {outShift_ff[5:0], 1'b0};

	// Output enable: only after identify match, off after a write byte.
	wire idPassed = (bitCnt_ff >= `SPX_ID_BITS_DONE) & ~idMiss;
	wire nxt_oe   = ~ceNS & ((inCtrl & idPassed) | inRead
	                         | (inWrite & ~byteDone)); // [R15] [R21]

	// Queue push for every whole byte in a write; format kept for writes only.
	// A byte that meets a full queue is lost, and byteDropped tells software
	// to release applyHold sooner or to space its writes.
	wire pushReq  = byteDone & (inWrite | inQuiet); // [R1] [R4]
	wire dropNow  = pushReq & ~qInReady;
	wire nxt_drop = (byteDropped & ~ceFall) | dropNow;
	assign pushWord = '{register_select_bit: ctrl_ff.register_select_bit,
	                    format: ctrl_ff.format, data: rxByte};

	// Apply path: the drain stalls while applyHold is high.
	// Holding the drain lets software gather several writes and release
	// them together; the queue depth bounds how many may wait.
	wire       doApply = qOutValid & ~applyHold;
	wire [7:0] target  = popWord.register_select_bit ? dirReg_ff
	                                                 : dataReg_ff; // [R2]
	wire [7:0] applied =
		(popWord.format == `SPX_FMT_CLEAR) ? (target & ~popWord.data) : // [R6]
		(popWord.format == `SPX_FMT_SET)   ? (target | popWord.data) : // [R7]
		popWord.data; // [R5]

	// Phase sequencing across one enable-low frame.
	// A raised enable always returns to idle, so a cut frame never leaves
	// the engine stuck in the middle of a byte.
	always_comb begin
		nxt_state = state_ff;
		if (ceNS) begin
			nxt_state = serial_port_expander_io_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				serial_port_expander_io_pkg::ST_IDLE: begin
					if (ceFall) nxt_state = serial_port_expander_io_pkg::ST_CTRL; // [R1]
				end
				serial_port_expander_io_pkg::ST_CTRL: begin
					if (idMiss) begin
						nxt_state = serial_port_expander_io_pkg::ST_IGNORE; // [R21]
					end else if (byteDone) begin
						nxt_state = rxCtrl.writeDir
							? serial_port_expander_io_pkg::ST_WRITE
							: serial_port_expander_io_pkg::ST_READ; // [R3]
					end
				end
				serial_port_expander_io_pkg::ST_WRITE: begin
					if (byteDone) nxt_state = serial_port_expander_io_pkg::ST_QUIET; // [R15]
				end
				default: nxt_state = state_ff;
			endcase
		end
	end

	// Phase, edge history and enable-fall captures.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_ff    <= serial_port_expander_io_pkg::ST_IDLE;
			sckPrev_ff  <= 1'b0;
			// The cleared synchroniser reads the enable as low, so the history
			// starts low too; a high value here would fake an enable fall on
			// the first clock after reset. A frame open at release is skipped.
			cePrev_ff   <= 1'b0;
			idleLvl_ff  <= 1'b0;
			compareFlag <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			sckPrev_ff <= sckS;
			cePrev_ff  <= ceNS;
			if (ceFall) begin
				idleLvl_ff  <= sckS; // [R11]
				compareFlag <= cmpNow; // [R20]
			end
		end
	end

	// Bit counter and receive shifter; a new frame starts at bit zero.
	// A partial byte at enable rise is dropped because byteDone never fires.
	always_ff @(posedge mclk) begin
		if (rst) begin
			bitCnt_ff  <= 3'h0;
			inShift_ff <= 7'h00;
		end else if (ceFall) begin
			bitCnt_ff  <= 3'h0; // [R10]
		end else if (sckTrail) begin
			bitCnt_ff  <= bitCnt_ff + 3'h1; // [R10]
			inShift_ff <= rxByte[6:0]; // [R9]
		end
	end

	// Control byte and compare mode; a foreign control byte is never kept.
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_ff    <= '0;
			cmpMode_ff <= `SPX_CMP_ANY_MISMATCH;
		end else if (inCtrl && byteDone) begin
			ctrl_ff    <= rxCtrl; // [R1]
			cmpMode_ff <= rxCtrl.compareSel; // [R8]
		end
	end

	// Transmitter: the next bit appears on each leading edge.
	// Loading on the leading edge gives the master half a period of setup
	// before it samples on the trailing edge.
	always_ff @(posedge mclk) begin
		if (rst) begin
			serialOut   <= 1'b0;
			outShift_ff <= 7'h00;
		end else if (sckLead && talking) begin
			serialOut   <= nxtMiso; // [R9] [R12]
			outShift_ff <= nxtOutShift;
		end
	end

	// Output enable and status flags; a drop in the fall cycle still sticks.
	// The full flag is one clock late, which is fine for software polling.
	always_ff @(posedge mclk) begin
		if (rst) begin
			serialOutOe    <= 1'b0;
			byteDropped    <= 1'b0;
			writeQueueFull <= 1'b0;
		end else begin
			serialOutOe    <= nxt_oe; // [R15] [R21]
			byteDropped    <= nxt_drop;
			writeQueueFull <= ~qInReady;
		end
	end

	// Registers load from the queue; port pins follow the flip-flops.
	// The direction register resets to all inputs so that no pin fights an
	// outside driver before software has configured it.
	always_ff @(posedge mclk) begin
		if (rst) begin
			dataReg_ff <= `SPX_DATA_RESET;
			dirReg_ff  <= `SPX_DIR_RESET; // [R18]
		end else if (doApply) begin
			if (popWord.register_select_bit) dirReg_ff <= applied; // [R2]
			else dataReg_ff <= applied; // [R16]
		end
	end

	// Direction 1 drives the pin from the data latch.
	assign port_pinsOut = dataReg_ff; // [R18]
	assign port_pinsOe  = dirReg_ff; // [R18]

	// The queue decouples byte arrival from register update.
	// Keeping the register update off the serial path lets the link run
	// without waiting for the apply logic.
	byte_fifo #(
		.WIDTH (WW),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.mclk     (mclk),
		.rst      (rst),
		.inValid  (pushReq),
		.inReady  (qInReady),
		.inData   (pushWord),
		.outValid (qOutValid),
		.outReady (~applyHold),
		.outData  (popWord)
	);

endmodule // serial_port_expander_io
`default_nettype wire

// ==== design/sync_two_ff.sv ====
// Two flip-flop synchroniser for a bundle of asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// Levels in and out
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_ff;

	// The first stage feeds only the second stage, never any logic.
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_ff <= '0;
			dout    <= '0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end

endmodule // sync_two_ff
`default_nettype wire

// ==== shared/serial_port_expander_io_consts.svh ====
// Constants for the serial port expander: fields, codes and reset values.
`ifndef SERIAL_PORT_EXPANDER_IO_CONSTS_SVH
`define SERIAL_PORT_EXPANDER_IO_CONSTS_SVH

// Reset values of the data register and the data direction register.
`define SPX_DATA_RESET       8'h00
`define SPX_DIR_RESET        8'h00

// Compare mode codes.
`define SPX_CMP_ANY_MISMATCH 2'h0
`define SPX_CMP_ALL_MATCH    2'h1
`define SPX_CMP_ALL_MISMATCH 2'h2
`define SPX_CMP_ANY_MATCH    2'h3

// Write data format codes; an upper bit of zero means plain data.
`define SPX_FMT_CLEAR        2'h2
`define SPX_FMT_SET          2'h3

// Bit counter positions inside one byte.
`define SPX_LAST_BIT         3'h7
`define SPX_ID_LAST_BIT      3'h1
`define SPX_ID_BITS_DONE     3'h2

// Width of the synchronised pin bundle: clock, enable, data, identify, port.
`define SPX_SYNC_WIDTH       13

// Default depth of the write byte queue.
`define SPX_QUEUE_DEPTH      4

`endif

// ==== shared/serial_port_expander_io_pkg.sv ====
// Types shared by the serial port expander design files.
`default_nettype none
package serial_port_expander_io_pkg;

	// Control byte as it arrives, most significant field first.
	typedef struct packed {
		logic       identify_bit_high;
		logic       identify_bit_low;
		logic       register_select_bit;
		logic       writeDir;
		logic [1:0] format;
		logic [1:0] compareSel;
	} control_t;

	// One queued write: target register, format and the received byte.
	typedef struct packed {
		logic       register_select_bit;
		logic [1:0] format;
		logic [7:0] data;
	} wr_word_t;

	// Transfer phases of the serial engine.
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CTRL   = 3'b001,
		ST_READ   = 3'b010,
		ST_WRITE  = 3'b011,
		ST_QUIET  = 3'b100,
		ST_IGNORE = 3'b101
	} phase_t;

endpackage
`default_nettype wire

// ==== test/serial_master_model.sv ====
// Link master that frames bytes with a chosen clock idle level.
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
	// Clock
	input  wire logic       mclk,
	// Link pins
	output logic            sck,
	output logic            ceN,
	output logic            mosi,
	input  wire logic       miso,
	// Received byte report
	output logic      [7:0] rxByte,
	output logic            rxDone
);
	logic idle;
	// The link clock stands still at its idle level outside frames.
	initial begin
		{idle, sck, ceN, mosi, rxDone} = 5'h04;
		rxByte = 8'h00;
	end
	// Park the clock first so the device latches the intended idle level.
	task automatic frame_start(input logic pol);
		idle = pol;
		sck = pol;
		repeat (4) @(negedge mclk);
		ceN = 1'b0;
		repeat (4) @(negedge mclk);
	endtask
	// One clock pulse per bit; data leaves on the leading edge and the
	// answer is taken on the trailing one.
	task automatic xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			sck = ~idle;
			repeat (4) @(negedge mclk);
			sck = idle;
			rxByte[i] = miso;
			repeat (4) @(negedge mclk);
		end
		rxDone = 1'b1;
		@(negedge mclk);
		rxDone = 1'b0;
	endtask
	// A quiet gap keeps the next enable fall clear of synchroniser lag.
	task automatic frame_end;
		ceN = 1'b1;
		repeat (12) @(negedge mclk);
	endtask
endmodule // serial_master_model
`default_nettype wire

// ==== test/serial_port_expander_io_props.sv ====
// Concurrent checks on the port expander's pins and status outputs.
`timescale 1ns/1ps
`default_nettype none
module serial_port_expander_io_props #(
	parameter int QUEUE_DEPTH = 4
) (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Serial link pins
	input wire logic       serialClk,
	input wire logic       chipEnableN,
	input wire logic       serialOut,
	input wire logic       serialOutOe,
	// Port and status
	input wire logic [7:0] port_pinsOut,
	input wire logic [7:0] port_pinsOe,
	input wire logic       applyHold,
	input wire logic       compareFlag,
	input wire logic       writeQueueFull,
	input wire logic       byteDropped
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Cycles since the enable pin was seen to fall; it saturates so that long
	// idle stretches never wrap back into the latch window.
	logic       ceN_ff;
	logic [3:0] sinceFall_ff;
	logic [3:0] nxt_sinceFall;
	logic       inWindow;
	assign nxt_sinceFall = (ceN_ff && !chipEnableN) ? 4'h0 :
		(sinceFall_ff == 4'hF) ? 4'hF : sinceFall_ff + 4'h1;
	assign inWindow = sinceFall_ff >= 4'h1 && sinceFall_ff <= 4'h6;
	always_ff @(posedge mclk) begin
		ceN_ff       <= chipEnableN;
		sinceFall_ff <= rst ? 4'hF : nxt_sinceFall;
	end
	chk_flag_latch: assert property ($changed(compareFlag) |-> inWindow)
		else $error("Compare flag moved away from an enable fall.");
	chk_drop_clear: assert property ($fell(byteDropped) |-> inWindow)
		else $error("Drop flag cleared away from an enable fall.");
	chk_drop_full: assert property ($rose(byteDropped) |-> writeQueueFull)
		else $error("Byte dropped while the queue was not full.");
	chk_pins_apply: assert property (
		$changed({port_pinsOut, port_pinsOe}) |-> !$past(applyHold))
		else $error("Port registers changed while held.");
	chk_oe_rise: assert property ($rose(serialOutOe) |->
		!$past(chipEnableN, 4) && !$past(chipEnableN, 12))
		else $error("Output enabled before the identify bits arrived.");
	chk_oe_release: assert property (
		$rose(chipEnableN) |-> ##[1:5] !serialOutOe)
		else $error("Output still driven after deselect.");
	chk_oe_quiet: assert property (chipEnableN[*7] |-> !serialOutOe)
		else $error("Output driven while deselected.");
	chk_out_shift: assert property (
		serialOutOe && $past(serialOutOe) && $changed(serialOut)
		|-> $past(serialClk, 2) != $past(serialClk, 5))
		else $error("Serial output moved away from a clock edge.");
	cover property ($rose(byteDropped));
	cover property ($rose(serialOutOe));
	cover property ($changed(port_pinsOe));
endmodule // serial_port_expander_io_props
bind serial_port_expander_io serial_port_expander_io_props #(
	.QUEUE_DEPTH(QUEUE_DEPTH)
) serial_port_expander_io_props_inst (
	.mclk(mclk), .rst(rst), .serialClk(serialClk),
	.chipEnableN(chipEnableN), .serialOut(serialOut),
	.serialOutOe(serialOutOe), .port_pinsOut(port_pinsOut),
	.port_pinsOe(port_pinsOe), .applyHold(applyHold),
	.compareFlag(compareFlag), .writeQueueFull(writeQueueFull),
	.byteDropped(byteDropped)
);
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the serial port expander with a link master.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        applyHold = 1'b0;
	logic        idHi = 1'b0;
	logic        idLo = 1'b0;
	logic        wobble = 1'b0;
	logic [7:0]  pins = 8'h00;
	logic [7:0]  dReg = 8'h00;
	logic [7:0]  dirReg = 8'h00;
	logic [1:0]  mode = 2'h0;
	logic [15:0] expQ[$];
	logic [15:0] expHead;
	int          lim = 99;
	int          miscompares = 0;
	int          nCompared = 0;
	wire logic   sck, ceN, mosi, miso, rxDone, serialOut, serialOutOe;
	wire logic   compareFlag, writeQueueFull, byteDropped;
	wire logic [7:0] rxByte, pinsOut, pinsOe;

	always #20 mclk = ~mclk;
	// A released output line shows a level that changes every cycle.
	always @(posedge mclk) wobble <= ~wobble;
	assign miso = serialOutOe ? serialOut : wobble;

	serial_port_expander_io #(.QUEUE_DEPTH(4)) serial_port_expander_io_inst (
		.mclk(mclk), .rst(rst), .serialClk(sck), .chipEnableN(ceN),
		.serialIn(mosi), .serialOut(serialOut), .serialOutOe(serialOutOe),
		.identify_bit_high(idHi), .identify_bit_low(idLo),
		.port_pinsIn(pins), .port_pinsOut(pinsOut), .port_pinsOe(pinsOe),
		.applyHold(applyHold), .compareFlag(compareFlag),
		.writeQueueFull(writeQueueFull), .byteDropped(byteDropped));
	serial_master_model serial_master_model_inst (
		.mclk(mclk), .sck(sck), .ceN(ceN), .mosi(mosi), .miso(miso),
		.rxByte(rxByte), .rxDone(rxDone));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Output pins count as matching, so only input bits can differ.
	function automatic logic cmpf(input logic [1:0] m, input logic [7:0] d,
			input logic [7:0] r, input logic [7:0] p);
		logic [7:0] eq;
		eq = ~(d ^ p) | r;
		case (m)
			2'h0: return ~&eq;
			2'h1: return &eq;
			2'h2: return ~|eq;
			default: return |eq;
		endcase
	endfunction

	// Each byte the master completes meets the oldest expectation; a zero
	// mask marks bit times when the line is not driven.
	always @(posedge rxDone) begin
		expHead = expQ.pop_front();
		check(rxByte & expHead[15:8], expHead[7:0]);
	end

	// One frame: control byte, then n data bytes counting up from d.
	task automatic op(input logic pol, input logic [7:0] c,
			input logic [7:0] d, input int n);
		logic       f;
		logic       hit;
		logic [7:0] rv;
		logic [7:0] wd;
		f = cmpf(mode, dReg, dirReg, pins);
		hit = c[7:6] == {idHi, idLo};
		expQ.push_back(hit ? {8'h3F, 2'h0, {6{f}}} : 16'h0000);
		serial_master_model_inst.frame_start(pol);
		serial_master_model_inst.xfer(c);
		check({7'h00, compareFlag}, {7'h00, f});
		if (hit)
			mode = c[1:0];
		for (int i = 0; i < n; i++) begin
			rv = c[5] ? dirReg : c[4] ? dReg : dReg & dirReg | pins & ~dirReg;
			wd = d + 8'(i);
			expQ.push_back(hit && !(c[4] && i > 0) ? {8'hFF, rv} : 16'h0000);
			serial_master_model_inst.xfer(wd);
			if (hit && c[4] && i < lim) begin
				rv = !c[3] ? wd : c[2] ? rv | wd : rv & ~wd;
				if (c[5])
					dirReg = rv;
				else
					dReg = rv;
			end
		end
		serial_master_model_inst.frame_end();
	endtask

	// Writes in every format to both registers, each followed by a repeated
	// read, then an identify miss and a queue overrun.
	initial begin
		logic [7:0] c;
		void'($urandom(32'h1ff00e40));
		{idHi, idLo} = 2'($urandom);
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		check(pinsOe, 8'h00);
		for (int k = 0; k < 16; k++) begin
			pins = 8'($urandom);
			c = {idHi, idLo, k[0], 1'b1, k[2:1], k[3:2]};
			op(k[1] ^ k[3], c, 8'($urandom), 1);
			check(pinsOut, dReg);
			check(pinsOe, dirReg);
			c = {c[7:5], 1'b0, 2'($urandom), c[1:0]};
			op(k[2], c, 8'h00, 2);
		end
		op(1'b0, {~idHi, idLo, 6'h3C}, 8'hFF, 1);
		check(pinsOut, dReg);
		applyHold = 1'b1;
		lim = 4;
		op(1'b1, {idHi, idLo, 6'h10}, 8'($urandom), 5);
		check({6'h00, byteDropped, writeQueueFull}, 8'h03);
		applyHold = 1'b0;
		lim = 99;
		repeat (16) @(negedge mclk);
		check(pinsOut, dReg);
		op(1'b0, {idHi, idLo, 6'h00}, 8'h00, 1);
		check({7'h00, byteDropped}, 8'h00);
		finish_test;
	end

	// Cut a hang short well beyond the length of the sequence above.
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		finish_test;
	end
endmodule // tb_top
`default_nettype wire
